// [rtl/ccd_timing_pkg.sv]
// Purpose: constants shared by the readout timing generator, the sensor model and the bench
// Assumes: 50 MHz system clock
// Notes:   geometry counts are fixed by the sensor; times are in ns
package ccd_timing_pkg;
    // ----------------------------------------------------------------
    // clock and pixel timing
    // ----------------------------------------------------------------
    localparam int         CLK_NS      = 20;
    localparam int         PIX_NS      = 250;
    localparam int         PIX_MIN_NS  = 100;
    localparam int         TV_NS       = 2000;
    localparam int         THS_NS      = 1000;
    localparam logic [3:0] PIX_CYC     = 4'(PIX_NS / CLK_NS);
    localparam logic [3:0] PIX_MIN_CYC = 4'((PIX_MIN_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] HALF_PH     = 4'(PIX_CYC / 2);
    localparam logic [3:0] SAMPLE_PH   = HALF_PH;
    localparam logic [3:0] RESET_PH    = 4'(HALF_PH + 4'h2);
    localparam int         PER_NS      = PIX_CYC * CLK_NS;
    localparam logic [5:0] TV_PER      = 6'((TV_NS + PER_NS - 1) / PER_NS);
    localparam logic [5:0] THS_PER     = 6'((THS_NS + PER_NS - 1) / PER_NS);
    localparam logic [5:0] VX_LAST     = 6'(3 * TV_PER + THS_PER - 6'h1);

    // ----------------------------------------------------------------
    // array geometry
    // ----------------------------------------------------------------
    localparam logic [9:0] VCOLS       = 10'h310;  // 784 vertical columns
    localparam logic [9:0] ROWS        = 10'h208;  // 520 elements per column
    localparam logic [9:0] HREG_LEN    = 10'h31C;  // 796 horizontal elements
    localparam logic [9:0] ACTIVE_COLS = 10'h300;  // 768
    localparam logic [9:0] ACTIVE_ROWS = 10'h200;  // 512
    localparam logic [9:0] LEAD_DUMMY  = 10'h00A;
    localparam logic [9:0] TRAIL_DUMMY = 10'h002;
    localparam logic [9:0] LEAD_DARK   = 10'h004;
    localparam logic [9:0] TRAIL_DARK  = 10'h00C;
    localparam logic [9:0] DARK_LINES  = 10'h004;

    // ----------------------------------------------------------------
    // pixel kind tag carried with each sample
    // ----------------------------------------------------------------
    localparam logic [1:0] KIND_DUMMY     = 2'h0;
    localparam logic [1:0] KIND_DARK_FAR  = 2'h1;
    localparam logic [1:0] KIND_DARK_NEAR = 2'h2;
    localparam logic [1:0] KIND_ACTIVE    = 2'h3;

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_VXFER = 2'b01,
        S_SHIFT = 2'b10
    } seq_state_e;
endpackage

// [rtl/sample_fifo.sv]
// Purpose: small sample buffer between converter and consumer
// Assumes: one clock, synchronous active-high reset
// Notes:   head sits in slot 0 so the output is a flip-flop
`timescale 1ns/1ns
module sample_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 4
) (
    input  wire logic             clock,     // system clock
    input  wire logic             reset,     // synchronous reset
    input  wire logic             in_valid,  // write request
    output logic                  in_ready,  // room for a word
    input  wire logic [WIDTH-1:0] in_data,   // word written
    output logic                  out_valid, // head holds a word
    input  wire logic             out_ready, // consumer takes head
    output logic      [WIDTH-1:0] out_data   // head word
);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem      [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [CW-1:0]    count;
    logic [CW-1:0]    next_count;
    logic             next_valid;
    logic             push;
    logic             pop;
    logic [CW-1:0]    wr_idx;

    assign in_ready = (count < CW'(DEPTH));
    assign out_data = mem[0];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        push       = in_valid && in_ready;
        pop        = out_valid && out_ready;
        wr_idx     = count - CW'(pop);
        next_count = count + CW'(push) - CW'(pop);
        next_valid = (next_count != '0);
        for (int i = 0; i < DEPTH; i++) begin
            next_mem[i] = mem[i];
            if (pop && i < DEPTH - 1) begin
                next_mem[i] = mem[i + 1];
            end
            if (push && wr_idx == CW'(i)) begin
                next_mem[i] = in_data;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            count     <= '0;
            out_valid <= 1'b0;
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else begin
            count     <= next_count;
            out_valid <= next_valid;
            mem       <= next_mem;
        end
    end
endmodule

// [rtl/ccd_readout_timing.sv]
// Purpose: clock timing generator driving a two-phase full-frame sensor
// Assumes: converter returns a sample within 5 clocks of the strobe
// Notes:   all sequencing advances on a pixel-period enable pulse
//
// Summary of operation
// - vertical phases held low while integrating
// - row loads on phase-two fall, H1 high
// - horizontal phases toggle alternately, always opposite
// - reset gate pulses after each sample
// - reset gate clocked every pixel period
// - pixel period at least 100 ns
`timescale 1ns/1ns
module ccd_readout_timing
    import ccd_timing_pkg::*;
#(
    parameter int DATA_W = 12,
    parameter int DEPTH  = 4
) (
    input  wire logic              clock,                // 50 MHz system clock
    input  wire logic              resetn,               // async reset, active low
    input  wire logic              start,                // begin frame readout
    input  wire logic              adc_valid,            // converter result valid
    input  wire logic [DATA_W-1:0] adc_data,             // converter result
    output logic                   vertical_phase_one,   // vertical clock 1
    output logic                   vertical_phase_two,   // vertical clock 2
    output logic                   horizontal_phase_one, // horizontal clock 1
    output logic                   horizontal_phase_two, // horizontal clock 2
    output logic                   reset_gate,           // sense node reset
    output logic                   sample_strobe,        // converter start
    output logic                   busy,                 // readout in progress
    output logic                   pix_valid,            // buffered pixel ready
    input  wire logic              pix_ready,            // consumer takes pixel
    output logic [DATA_W+1:0]      pix_data              // {kind, brightness}
);
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta;
    logic rst_sync;
    logic reset;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end
    assign reset = !rst_sync;

    // ----------------------------------------------------------------
    // pixel classification
    // ----------------------------------------------------------------
    function automatic logic [1:0] pixel_kind(input logic [9:0] c, input logic [9:0] r);
        logic [9:0] ac;
        logic       dark_col;
        logic       dark_row;
        logic       near;
        ac       = c - LEAD_DUMMY;
        dark_col = (ac < LEAD_DARK) || (ac >= LEAD_DARK + ACTIVE_COLS);
        dark_row = (r < DARK_LINES) || (r >= DARK_LINES + ACTIVE_ROWS);
        // shielded pixels touching the active area can scavenge charge
        near     = ((ac == LEAD_DARK - 10'h1 || ac == LEAD_DARK + ACTIVE_COLS) && !dark_row)
                || ((r == DARK_LINES - 10'h1 || r == DARK_LINES + ACTIVE_ROWS) && !dark_col);
        if (c < LEAD_DUMMY || c >= HREG_LEN - TRAIL_DUMMY) begin
            pixel_kind = KIND_DUMMY;
        end else if (!dark_col && !dark_row) begin
            pixel_kind = KIND_ACTIVE;
        end else if (near) begin
            pixel_kind = KIND_DARK_NEAR;
        end else begin
            pixel_kind = KIND_DARK_FAR;
        end
    endfunction

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    seq_state_e  state;
    seq_state_e  next_state;
    logic [3:0]  ph;
    logic [3:0]  next_ph;
    logic [5:0]  vcnt;
    logic [5:0]  next_vcnt;
    logic [9:0]  col;
    logic [9:0]  next_col;
    logic [9:0]  row;
    logic [9:0]  next_row;
    logic        req;
    logic        next_req;
    logic [1:0]  tag_kind;
    logic [1:0]  next_tag_kind;
    logic        next_v1;
    logic        next_v2;
    logic        next_h1;
    logic        next_rg;
    logic        next_strobe;
    logic        next_busy;
    logic        tick;
    logic        stall;
    logic        fifo_ready;

    always_comb begin
        next_state    = state;
        next_vcnt     = vcnt;
        next_col      = col;
        next_row      = row;
        next_req      = req || start;
        next_tag_kind = tag_kind;
        // hold just before the strobe while full; a slow converter lands as late as ph 0
        stall         = (state == S_SHIFT) && (ph == HALF_PH - 4'h1) && !fifo_ready;
        tick          = (ph == PIX_CYC - 4'h1);
        next_ph       = stall ? ph : (tick ? 4'h0 : ph + 4'h1);
        if (tick) begin
            case (state)
                S_IDLE: begin
                    if (req) begin
                        next_state = S_VXFER;
                        next_req   = start;
                        next_vcnt  = '0;
                        next_row   = '0;
                    end
                end
                S_VXFER: begin
                    next_vcnt = vcnt + 6'h1;
                    if (vcnt == VX_LAST) begin
                        next_state = S_SHIFT;
                        next_col   = '0;
                    end
                end
                S_SHIFT: begin
                    next_col = col + 10'h1;
                    // one extra period lets the last packet be sampled
                    if (col == HREG_LEN) begin
                        next_vcnt = '0;
                        if (row == ROWS - 10'h1) begin
                            next_state = S_IDLE;
                        end else begin
                            next_state = S_VXFER;
                            next_row   = row + 10'h1;
                        end
                    end
                end
                default: begin
                    next_state = S_IDLE;
                end
            endcase
        end
        next_v1     = (state == S_VXFER) && (vcnt < TV_PER);
        next_v2     = (state == S_VXFER) && (vcnt >= TV_PER) && (vcnt < 6'(2 * TV_PER));
        next_h1     = !((state == S_SHIFT) && (col < HREG_LEN) && (ph >= HALF_PH));
        next_rg     = (ph == RESET_PH);
        next_strobe = (state == S_SHIFT) && (col != 10'h0) && (ph == SAMPLE_PH);
        next_busy   = (state != S_IDLE);
        if (next_strobe) begin
            next_tag_kind = pixel_kind(col - 10'h1, row);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state                <= S_IDLE;
            ph                   <= '0;
            vcnt                 <= '0;
            col                  <= '0;
            row                  <= '0;
            req                  <= 1'b0;
            tag_kind             <= KIND_DUMMY;
            vertical_phase_one   <= 1'b0;
            vertical_phase_two   <= 1'b0;
            horizontal_phase_one <= 1'b1;
            horizontal_phase_two <= 1'b0;
            reset_gate           <= 1'b0;
            sample_strobe        <= 1'b0;
            busy                 <= 1'b0;
        end else begin
            state                <= next_state;
            ph                   <= next_ph;
            vcnt                 <= next_vcnt;
            col                  <= next_col;
            row                  <= next_row;
            req                  <= next_req;
            tag_kind             <= next_tag_kind;
            vertical_phase_one   <= next_v1;
            vertical_phase_two   <= next_v2;
            horizontal_phase_one <= next_h1;
            horizontal_phase_two <= !next_h1;
            reset_gate           <= next_rg;
            sample_strobe        <= next_strobe;
            busy                 <= next_busy;
        end
    end

    // ----------------------------------------------------------------
    // sample buffer
    // ----------------------------------------------------------------
    sample_fifo #(
        .WIDTH (DATA_W + 2),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clock     (clock),
        .reset     (reset),
        .in_valid  (adc_valid),
        .in_ready  (fifo_ready),
        .in_data   ({tag_kind, ~adc_data}),
        .out_valid (pix_valid),
        .out_ready (pix_ready),
        .out_data  (pix_data)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [9:0] h2_falls;

    always_ff @(posedge clock) begin
        if (reset || (vertical_phase_two && !$past(vertical_phase_two))) begin
            h2_falls <= '0;
        end else if (!horizontal_phase_two && $past(horizontal_phase_two)) begin
            h2_falls <= h2_falls + 10'h1;
        end
    end

    idle_v_low_a: assert property (@(posedge clock) disable iff (reset)
        !busy |-> !vertical_phase_one && !vertical_phase_two)
        else $error("vertical clock active while integrating");

    row_load_h1_a: assert property (@(posedge clock) disable iff (reset)
        $fell(vertical_phase_two) |-> horizontal_phase_one ##1 horizontal_phase_one[*8])
        else $error("horizontal phase one low at row load");

    h_complement_a: assert property (@(posedge clock) disable iff (reset)
        horizontal_phase_one != horizontal_phase_two)
        else $error("horizontal phases not complementary");

    reset_after_sample_a: assert property (@(posedge clock) disable iff (reset)
        sample_strobe |-> !reset_gate ##2 reset_gate)
        else $error("reset gate not pulsed after sample");

    reset_each_period_a: assert property (@(posedge clock) disable iff (reset)
        $rose(horizontal_phase_two) |-> ##[1:12] reset_gate)
        else $error("reset gate missing in pixel period");

    pixel_period_a: assert property (@(posedge clock) disable iff (reset)
        $fell(horizontal_phase_two) |-> !horizontal_phase_two[*5])
        else $error("pixel period shorter than minimum");

    shifts_per_row_a: assert property (@(posedge clock) disable iff (reset)
        $rose(vertical_phase_two) |-> (h2_falls == 10'h0) || (h2_falls == HREG_LEN))
        else $error("wrong number of horizontal shifts in row");
endmodule

// [tb/ccd_sensor_model.sv]
// Purpose: behavioural sensor and converter on the far side of the generator
// Assumes: generator outputs change just after the rising clock edge
// Notes:   breaches of the phase rules are counted in faults for the bench
`timescale 1ns/1ns
module ccd_sensor_model
    import ccd_timing_pkg::*;
#(
    parameter int DATA_W = 12
) (
    input  wire logic              clock,                // system clock
    input  wire logic              vertical_phase_one,   // vertical clock 1
    input  wire logic              vertical_phase_two,   // vertical clock 2
    input  wire logic              horizontal_phase_one, // horizontal clock 1
    input  wire logic              horizontal_phase_two, // horizontal clock 2
    input  wire logic              reset_gate,           // sense node reset
    input  wire logic              sample_strobe,        // converter start
    input  wire logic              busy,                 // not integrating
    input  wire logic              relax,                // skip timing checks
    input  wire logic              slow,                 // answer at latest clock
    output logic                   adc_valid,            // result valid
    output logic      [DATA_W-1:0] adc_data,             // video level
    output int                     faults                // breaches seen
);
    logic              v2_q = 1'b0;
    logic              h2_q = 1'b0;
    logic              pend = 1'b0;
    logic [DATA_W-1:0] held = '0;
    int                elem = -1;
    int                row  = -1;
    int                gap  = 0;
    int                hgap = 0;
    int                wcnt = 0;

    initial begin
        adc_valid = 1'b0;
        adc_data  = '0;
        faults    = 0;
    end

    // ------------------------------------------------------------
    // charge transport and converter
    // ------------------------------------------------------------
    always @(posedge clock) begin
        v2_q <= vertical_phase_two;
        h2_q <= horizontal_phase_two;
        gap  <= reset_gate ? 0 : gap + 1;
        hgap <= hgap + 1;
        adc_valid <= 1'b0;
        if (reset_gate)
            pend <= 1'b0;
        if (v2_q && !vertical_phase_two) begin
            row  <= row + 1;
            elem <= -1;
            if ((!horizontal_phase_one && !relax) || row >= 519)
                faults <= faults + 1;
        end
        if (h2_q && !horizontal_phase_two) begin
            elem <= elem + 1;
            hgap <= 1;
            if ((!relax && (hgap < int'(PIX_MIN_CYC) || pend)) || elem >= 795)
                faults <= faults + 1;
        end
        if (!relax && (horizontal_phase_one == horizontal_phase_two || gap > int'(PIX_CYC)
                || (!busy && (vertical_phase_one || vertical_phase_two))))
            faults <= faults + 1;
        if (sample_strobe) begin
            pend <= 1'b1;
            held <= ~DATA_W'({row[1:0], elem[9:0]});
            if (slow) begin
                wcnt <= 4;
            end else begin
                adc_valid <= 1'b1;
                adc_data  <= ~DATA_W'({row[1:0], elem[9:0]});
            end
        end else if (wcnt > 0) begin
            wcnt <= wcnt - 1;
            if (wcnt == 1) begin
                adc_valid <= 1'b1;
                adc_data  <= held;
            end
        end else if (adc_valid) begin
            // released output: never let a stale value pass for fresh data
            adc_data <= ~adc_data;
        end
    end
endmodule

// [tb/ccd_frame_readout_sequencer_bench.sv]
// Purpose: self-checking bench for the readout timing generator
// Assumes: one 50 MHz clock; only the first rows of a frame are run
// Notes:   a whole frame is far too long, so five rows and a reset are used
`timescale 1ns/1ns
module ccd_frame_readout_sequencer_bench
    import ccd_timing_pkg::*;
;
    logic        clock;
    logic        resetn;
    logic        start;
    logic        pix_ready;
    logic        relax;
    logic        slow;
    logic        adc_valid;
    logic [11:0] adc_data;
    logic        vertical_phase_one;
    logic        vertical_phase_two;
    logic        horizontal_phase_one;
    logic        horizontal_phase_two;
    logic        reset_gate;
    logic        sample_strobe;
    logic        busy;
    logic        pix_valid;
    logic [13:0] pix_data;
    int          faults;
    int          n_mismatch = 0;
    int          cmp_count  = 0;
    int          n_pix      = 0;
    int          shifts     = 0;
    int          row_shifts = 0;
    logic        h2_q       = 1'b0;
    logic        v2_q       = 1'b0;

    ccd_readout_timing #(.DATA_W(12), .DEPTH(4)) i_ccd_readout_timing (
        .clock(clock), .resetn(resetn), .start(start), .adc_valid(adc_valid), .adc_data(adc_data),
        .vertical_phase_one(vertical_phase_one), .vertical_phase_two(vertical_phase_two),
        .horizontal_phase_one(horizontal_phase_one), .horizontal_phase_two(horizontal_phase_two),
        .reset_gate(reset_gate), .sample_strobe(sample_strobe), .busy(busy),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data));

    ccd_sensor_model #(.DATA_W(12)) i_ccd_sensor_model (
        .clock(clock), .vertical_phase_one(vertical_phase_one), .vertical_phase_two(vertical_phase_two),
        .horizontal_phase_one(horizontal_phase_one), .horizontal_phase_two(horizontal_phase_two),
        .reset_gate(reset_gate), .sample_strobe(sample_strobe), .busy(busy), .relax(relax),
        .slow(slow), .adc_valid(adc_valid), .adc_data(adc_data), .faults(faults));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // horizontal shifts counted per row, latched at each row load
    always @(posedge clock) begin
        h2_q <= horizontal_phase_two;
        v2_q <= vertical_phase_two;
        if (h2_q && !horizontal_phase_two)
            shifts <= shifts + 1;
        if (v2_q && !vertical_phase_two) begin
            row_shifts <= shifts;
            shifts     <= 0;
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    function automatic logic [1:0] kind_of(input int r, input int c);
        if (c < 10 || c >= 794)
            return 2'h0;
        if (r < 4 || r >= 516)
            return ((r == 3 || r == 516) && c >= 14 && c < 782) ? 2'h2 : 2'h1;
        if (c < 14 || c >= 782)
            return (c == 13 || c == 782) ? 2'h2 : 2'h1;
        return 2'h3;
    endfunction

    task automatic take_pixels(input int n);
        int got;
        int w;
        int r;
        int c;
        got = 0;
        w   = 0;
        pix_ready <= 1'b1;
        while (got < n && w < 1000) begin
            @(posedge clock);
            w++;
            if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
                r = n_pix / 796;
                c = n_pix % 796;
                check(32'(pix_data), 32'({kind_of(r, c), r[1:0], c[9:0]}));
                n_pix++;
                got++;
                w = 0;
            end
        end
        check(32'(got), 32'(n));
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_idle();
        int   pulses;
        logic vseen;
        pulses = 0;
        vseen  = 1'b0;
        repeat (10 * int'(PIX_CYC)) begin
            @(posedge clock);
            pulses += int'(reset_gate);
            vseen |= vertical_phase_one | vertical_phase_two;
        end
        check(32'(pulses), 32'h0000000A);
        check(32'(vseen), 32'h0);
        $display("idle test done");
    endtask

    task automatic t_vxfer();
        int n;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        n = 0;
        while (busy !== 1'b1 && n < 40) begin
            @(posedge clock);
            n++;
        end
        check(32'(vertical_phase_one), 32'h1);
        n = 0;
        while (vertical_phase_one === 1'b1 && n < 300) begin
            @(posedge clock);
            n++;
        end
        check(32'(n), 32'(int'(TV_PER) * int'(PIX_CYC)));
        n = 0;
        while (vertical_phase_two === 1'b1 && n < 300) begin
            @(posedge clock);
            n++;
        end
        check(32'(n), 32'(int'(TV_PER) * int'(PIX_CYC)));
        check(32'({horizontal_phase_one, vertical_phase_one}), 32'h2);
        $display("vertical transfer test done");
    endtask

    task automatic t_stall();
        logic [13:0] d;
        int          n;
        take_pixels(300);
        pix_ready <= 1'b0;
        relax     <= 1'b1;
        n = 0;
        // head slot is stale until the next sample lands
        do begin
            @(posedge clock);
            n++;
        end while (pix_valid !== 1'b1 && n < 24);
        d = pix_data;
        repeat (150) @(posedge clock);
        check(32'({pix_valid, pix_data}), 32'({1'b1, d}));
        check(32'(row_shifts), 32'h0000031C);
        slow <= 1'b1;
        take_pixels(496);
        relax <= 1'b0;
        $display("stall test done");
    endtask

    task automatic t_midreset();
        @(posedge clock);
        relax  <= 1'b1;
        resetn <= 1'b0;
        repeat (3) @(posedge clock);
        check(32'({vertical_phase_one, vertical_phase_two, horizontal_phase_one, horizontal_phase_two,
                   busy, pix_valid, reset_gate, sample_strobe}), 32'h20);
        resetn <= 1'b1;
        repeat (40) @(posedge clock);
        relax <= 1'b0;
        check(32'(busy), 32'h0);
        repeat (40) @(posedge clock);
        check(32'(faults), 32'h0);
        $display("mid reset test done");
    endtask

    // run is about 50000 cycles; watchdog allows 90000
    initial begin
        #1800000;
        n_mismatch++;
        conclude();
    end

    initial begin
        start     = 1'b0;
        pix_ready = 1'b0;
        resetn    = 1'b0;
        relax     = 1'b1;
        slow      = 1'b0;
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        check(32'({vertical_phase_one, vertical_phase_two, horizontal_phase_one, horizontal_phase_two,
                   busy, pix_valid}), 32'h08);
        repeat (16) @(posedge clock);
        relax <= 1'b0;
        $display("reset test done");
        t_idle();
        t_vxfer();
        take_pixels(796);
        $display("first row test done");
        t_stall();
        take_pixels(3 * 796);
        check(32'(row_shifts), 32'h0000031C);
        $display("dark and active rows test done");
        t_midreset();
        conclude();
    end
endmodule
